//--- timer_pkg.sv
// Constants for the capture/match timer: register offsets, field
// positions, reset values and encodings.
// Assumes a byte-addressed register port with 32-bit data words.
package timer_pkg;

  localparam int NUM_CH      = 4;
  localparam int PINS_PER_CH = 2;
  localparam int NUM_PINS    = NUM_CH * PINS_PER_CH;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_CTRL      = 8'h04;
  localparam logic [7:0] OFF_COUNT     = 8'h08;
  localparam logic [7:0] OFF_PRESCALE  = 8'h0c;
  localparam logic [7:0] OFF_PRE_COUNT = 8'h10;
  localparam logic [7:0] OFF_MATCH_CTL = 8'h14;
  localparam logic [7:0] OFF_MATCH0    = 8'h18;
  localparam logic [7:0] OFF_CAP_CTL   = 8'h28;
  localparam logic [7:0] OFF_CAPTURE0  = 8'h2c;
  localparam logic [7:0] OFF_EXT_MATCH = 8'h3c;
  localparam logic [7:0] OFF_COUNT_CTL = 8'h40;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h44;
  localparam logic [7:0] OFF_PIN_CFG   = 8'h48;

  // Control register fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_RST_BIT = 1;

  // Per-channel field groups
  localparam int MCTL_STRIDE = 3;
  localparam int MCTL_INT    = 0;
  localparam int MCTL_RST    = 1;
  localparam int MCTL_STOP   = 2;
  localparam int CCTL_STRIDE = 3;
  localparam int CCTL_RISE   = 0;
  localparam int CCTL_FALL   = 1;
  localparam int CCTL_INT    = 2;

  // External match register: states in low nibble, actions above
  localparam int EXT_ACT_LSB = 4;

  // Count control: mode in bits 1:0, input select in bits 3:2
  localparam int CCTL_MODE_LSB = 0;
  localparam int CCTL_SEL_LSB  = 2;

  // Pin config: AND-combine per capture, broadcast enables per pin
  localparam int PCFG_AND_LSB   = 0;
  localparam int PCFG_BCAST_LSB = 8;

  // Status layout: matches low, captures high
  localparam int STAT_CAP_LSB = NUM_CH;

  // Match output actions
  localparam logic [1:0] ACT_NONE   = 2'h0;
  localparam logic [1:0] ACT_LOW    = 2'h1;
  localparam logic [1:0] ACT_HIGH   = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // Count source modes
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_RISE  = 2'h1;
  localparam logic [1:0] MODE_FALL  = 2'h2;
  localparam logic [1:0] MODE_BOTH  = 2'h3;

  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [7:0]  RST_BCAST = 8'hff;

  // Synchroniser depth and the fastest external count rate
  localparam int SYNC_STAGES     = 3;
  localparam int EXT_CLK_MIN_DIV = 4;

endpackage

//--- pin_sync.sv
// Three-stage synchroniser for asynchronous pins.
// Assumes the pins hold each level for at least two clock periods.
module pin_sync
  import timer_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // A change counts once the second and third stages agree
  always_comb begin
    next_level = o_level;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2[i] == stage3[i]) begin
        next_level[i] = stage3[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      stage1  <= '0;
      stage2  <= '0;
      stage3  <= '0;
      o_level <= '0;
    end else begin
      stage1  <= i_pin;
      stage2  <= stage1;
      stage3  <= stage2;
      o_level <= next_level;
    end
  end

endmodule

//--- match_unit.sv
// One match channel: equality against the count and the external
// match state that follows it.
// Assumes i_tick is a one-cycle pulse on the count's advance.
module match_unit
  import timer_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic [31:0] i_count,
  input  wire logic [31:0] i_value,
  input  wire logic        i_tick,
  input  wire logic [1:0]  i_action,
  input  wire logic        i_wr_en,
  input  wire logic        i_wr_state,
  output logic             o_hit,
  output logic             o_state
);

  logic next_state;

  assign o_hit = i_tick && (i_count == i_value);

  // A match outranks a software write in the same cycle
  always_comb begin
    next_state = o_state;
    if (o_hit) begin
      unique case (i_action)
        ACT_NONE:   next_state = o_state;
        ACT_LOW:    next_state = 1'b0;
        ACT_HIGH:   next_state = 1'b1;
        ACT_TOGGLE: next_state = ~o_state;
      endcase
    end else if (i_wr_en) begin
      next_state = i_wr_state;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_state <= 1'b0;
    end else begin
      o_state <= next_state;
    end
  end

endmodule

//--- capture_match_timer.sv
// 32-bit timer/counter with prescaler, four capture and four match
// channels, match output pins and one level interrupt.
// Assumes a single-cycle strobe register port and asynchronous pins.
//
// Notes on behaviour
// - Count advances once per prescale+1 source events, 32-bit counter.
// - Software picks clock cycles or external input edges as source.
// - Four capture channels copy count on chosen input edge, optional flag.
// - Four match values; on hit continue, stop or reset, optional flag.
// - Each match drives its output low, high, toggled or unchanged.
// - Event mode counts one selected capture input, up to clock/4.
// - Other capture inputs keep capturing while one serves as clock.
// - Two pins per channel, OR/AND combine in, broadcast match out.
// - All match and capture flags merge into one interrupt line.
module capture_match_timer
  import timer_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_rst,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic [DATA_W-1:0]   i_wr_data,
  input  wire logic                i_wr_en,
  input  wire logic                i_rd_en,
  output logic      [DATA_W-1:0]   o_rd_data,
  output logic                     o_irq,
  input  wire logic [NUM_PINS-1:0] i_capture_input_pin,
  output logic      [NUM_PINS-1:0] o_match_pin
);

  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] base,
                                   input int         idx);
    return addr == (base + 8'(idx * 4));
  endfunction

  logic [NUM_PINS-1:0] pin_lvl;
  logic [NUM_CH-1:0]   cap_lvl;
  logic [NUM_CH-1:0]   prev_lvl;
  logic [NUM_CH-1:0]   rise;
  logic [NUM_CH-1:0]   fall;
  logic [NUM_CH-1:0]   cap_ev;
  logic [NUM_CH-1:0]   hit;
  logic [NUM_CH-1:0]   ext_state;
  logic [NUM_CH-1:0]   mc_int;
  logic [NUM_CH-1:0]   mc_rst;
  logic [NUM_CH-1:0]   mc_stop;
  logic [NUM_CH-1:0]   cc_rise;
  logic [NUM_CH-1:0]   cc_fall;
  logic [NUM_CH-1:0]   cc_int;
  logic [NUM_CH-1:0]   ext_wr_state;
  logic                ext_wr;
  logic                ctrl_en;
  logic                ctrl_rst;
  logic                next_ctrl_en;
  logic                next_ctrl_rst;
  logic [31:0]         tc;
  logic [31:0]         next_tc;
  logic [31:0]         pr;
  logic [31:0]         next_pr;
  logic [31:0]         pc;
  logic [31:0]         next_pc;
  logic [31:0]         mr      [NUM_CH];
  logic [31:0]         next_mr [NUM_CH];
  logic [31:0]         cr      [NUM_CH];
  logic [31:0]         next_cr [NUM_CH];
  logic [11:0]         mctl;
  logic [11:0]         next_mctl;
  logic [11:0]         cctl;
  logic [11:0]         next_cctl;
  logic [7:0]          ext_act;
  logic [7:0]          next_ext_act;
  logic [3:0]          cnt_ctl;
  logic [3:0]          next_cnt_ctl;
  logic [7:0]          status;
  logic [7:0]          next_status;
  logic [7:0]          mask;
  logic [7:0]          next_mask;
  logic [3:0]          and_mode;
  logic [3:0]          next_and_mode;
  logic [7:0]          bcast;
  logic [7:0]          next_bcast;
  logic [7:0]          clr;
  logic [7:0]          set;
  logic [DATA_W-1:0]   next_rd_data;
  logic                next_irq;
  logic [NUM_PINS-1:0] next_match_pin;
  logic [1:0]          sel;
  logic [1:0]          mode;
  logic                src_pulse;
  logic                tick;

  pin_sync #(
    .WIDTH (NUM_PINS)
  ) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_pin     (i_capture_input_pin),
    .o_level   (pin_lvl)
  );

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [PINS_PER_CH-1:0] grp;
    assign grp = pin_lvl[c*PINS_PER_CH +: PINS_PER_CH];
    // Several pins feed one channel
    assign cap_lvl[c] = and_mode[c] ? &grp : |grp;
    assign rise[c]    = cap_lvl[c] & ~prev_lvl[c];
    assign fall[c]    = ~cap_lvl[c] & prev_lvl[c];
    assign mc_int[c]  = mctl[c*MCTL_STRIDE + MCTL_INT];
    assign mc_rst[c]  = mctl[c*MCTL_STRIDE + MCTL_RST];
    assign mc_stop[c] = mctl[c*MCTL_STRIDE + MCTL_STOP];
    assign cc_rise[c] = cctl[c*CCTL_STRIDE + CCTL_RISE];
    assign cc_fall[c] = cctl[c*CCTL_STRIDE + CCTL_FALL];
    assign cc_int[c]  = cctl[c*CCTL_STRIDE + CCTL_INT];
    // Every channel captures, the counting one included
    assign cap_ev[c]  = (rise[c] & cc_rise[c]) |
                        (fall[c] & cc_fall[c]);

    match_unit u_match (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_count    (tc),
      .i_value    (mr[c]),
      .i_tick     (tick),
      .i_action   (ext_act[EXT_ACT_LSB - NUM_CH + 2*c +: 2]),
      .i_wr_en    (ext_wr),
      .i_wr_state (ext_wr_state[c]),
      .o_hit      (hit[c]),
      .o_state    (ext_state[c])
    );
  end

  assign sel  = cnt_ctl[CCTL_SEL_LSB +: 2];
  assign mode = cnt_ctl[CCTL_MODE_LSB +: 2];

  // Count source: every clock, or edges of one selected input
  always_comb begin
    unique case (mode)
      MODE_TIMER: src_pulse = 1'b1;
      MODE_RISE:  src_pulse = rise[sel];
      MODE_FALL:  src_pulse = fall[sel];
      MODE_BOTH:  src_pulse = rise[sel] | fall[sel];
    endcase
  end

  assign tick = ctrl_en && !ctrl_rst && src_pulse && (pc == pr);

  always_comb begin
    next_ctrl_en  = ctrl_en;
    next_ctrl_rst = ctrl_rst;
    next_tc       = tc;
    next_pr       = pr;
    next_pc       = pc;
    next_mctl     = mctl;
    next_cctl     = cctl;
    next_ext_act  = ext_act;
    next_cnt_ctl  = cnt_ctl;
    next_mask     = mask;
    next_and_mode = and_mode;
    next_bcast    = bcast;
    ext_wr        = 1'b0;
    ext_wr_state  = i_wr_data[NUM_CH-1:0];
    clr           = '0;
    for (int c = 0; c < NUM_CH; c++) begin
      next_mr[c] = mr[c];
      next_cr[c] = cr[c];
      if (cap_ev[c]) begin
        next_cr[c] = tc;
      end
    end

    if (ctrl_rst) begin
      next_tc = '0;
      next_pc = '0;
    end else if (ctrl_en && src_pulse) begin
      if (pc == pr) begin
        next_pc = '0;
        next_tc = |(hit & mc_rst) ? '0 : tc + 32'h1;
      end else begin
        next_pc = pc + 32'h1;
      end
    end
    if (|(hit & mc_stop)) begin
      next_ctrl_en = 1'b0;
    end

    if (i_wr_en) begin
      case (i_addr)
        OFF_STATUS:    clr = i_wr_data[7:0];
        OFF_CTRL: begin
          next_ctrl_en  = i_wr_data[CTRL_EN_BIT];
          next_ctrl_rst = i_wr_data[CTRL_RST_BIT];
        end
        OFF_COUNT:     next_tc = i_wr_data;
        OFF_PRESCALE:  next_pr = i_wr_data;
        OFF_PRE_COUNT: next_pc = i_wr_data;
        OFF_MATCH_CTL: next_mctl = i_wr_data[11:0];
        OFF_CAP_CTL:   next_cctl = i_wr_data[11:0];
        OFF_EXT_MATCH: begin
          ext_wr       = 1'b1;
          next_ext_act = i_wr_data[EXT_ACT_LSB +: 8];
        end
        OFF_COUNT_CTL: next_cnt_ctl = i_wr_data[3:0];
        OFF_IRQ_MASK:  next_mask = i_wr_data[7:0];
        OFF_PIN_CFG: begin
          next_and_mode = i_wr_data[PCFG_AND_LSB +: 4];
          next_bcast    = i_wr_data[PCFG_BCAST_LSB +: 8];
        end
        default: ;
      endcase
      for (int c = 0; c < NUM_CH; c++) begin
        if (reg_hit(i_addr, OFF_MATCH0, c)) begin
          next_mr[c] = i_wr_data;
        end
      end
    end

    // A new event wins over a clear in the same cycle
    set         = {cap_ev & cc_int, hit & mc_int};
    next_status = (status & ~clr) | set;
    // New mask value, so the line follows a mask write at once
    next_irq    = |(next_status & next_mask);

    for (int p = 0; p < NUM_PINS; p++) begin
      next_match_pin[p] = ext_state[p / PINS_PER_CH] & next_bcast[p];
    end

    next_rd_data = '0;
    if (i_rd_en) begin
      case (i_addr)
        OFF_STATUS:    next_rd_data = {24'h0, status};
        OFF_CTRL:      next_rd_data = {30'h0, ctrl_rst, ctrl_en};
        OFF_COUNT:     next_rd_data = tc;
        OFF_PRESCALE:  next_rd_data = pr;
        OFF_PRE_COUNT: next_rd_data = pc;
        OFF_MATCH_CTL: next_rd_data = {20'h0, mctl};
        OFF_CAP_CTL:   next_rd_data = {20'h0, cctl};
        OFF_EXT_MATCH: next_rd_data = {20'h0, ext_act, ext_state};
        OFF_COUNT_CTL: next_rd_data = {28'h0, cnt_ctl};
        OFF_IRQ_MASK:  next_rd_data = {24'h0, mask};
        OFF_PIN_CFG:   next_rd_data = {16'h0, bcast, 4'h0, and_mode};
        default:       next_rd_data = '0;
      endcase
      for (int c = 0; c < NUM_CH; c++) begin
        if (reg_hit(i_addr, OFF_MATCH0, c)) begin
          next_rd_data = mr[c];
        end
        if (reg_hit(i_addr, OFF_CAPTURE0, c)) begin
          next_rd_data = cr[c];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_en     <= 1'b0;
      ctrl_rst    <= 1'b0;
      tc          <= RST_WORD;
      pr          <= RST_WORD;
      pc          <= RST_WORD;
      mctl        <= '0;
      cctl        <= '0;
      ext_act     <= '0;
      cnt_ctl     <= '0;
      status      <= '0;
      mask        <= '0;
      and_mode    <= '0;
      bcast       <= RST_BCAST;
      prev_lvl    <= '0;
      o_rd_data   <= RST_WORD;
      o_irq       <= 1'b0;
      o_match_pin <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        mr[c] <= RST_WORD;
        cr[c] <= RST_WORD;
      end
    end else begin
      ctrl_en     <= next_ctrl_en;
      ctrl_rst    <= next_ctrl_rst;
      tc          <= next_tc;
      pr          <= next_pr;
      pc          <= next_pc;
      mctl        <= next_mctl;
      cctl        <= next_cctl;
      ext_act     <= next_ext_act;
      cnt_ctl     <= next_cnt_ctl;
      status      <= next_status;
      mask        <= next_mask;
      and_mode    <= next_and_mode;
      bcast       <= next_bcast;
      prev_lvl    <= cap_lvl;
      o_rd_data   <= next_rd_data;
      o_irq       <= next_irq;
      o_match_pin <= next_match_pin;
      for (int c = 0; c < NUM_CH; c++) begin
        mr[c] <= next_mr[c];
        cr[c] <= next_cr[c];
      end
    end
  end

endmodule

//--- capture_match_timer_properties.sv
// Port checker for the capture/match timer.
// Assumes single-cycle strobes; bound to the top module after endmodule.
module capture_match_timer_checker
  import timer_pkg::*;
(
  input wire logic                i_sys_clk,
  input wire logic                i_rst,
  input wire logic [ADDR_W-1:0]   i_addr,
  input wire logic [DATA_W-1:0]   i_wr_data,
  input wire logic                i_wr_en,
  input wire logic                i_rd_en,
  input wire logic [DATA_W-1:0]   o_rd_data,
  input wire logic                o_irq,
  input wire logic [NUM_PINS-1:0] o_match_pin
);
  logic [7:0] mask;
  logic [7:0] next_mask;
  logic [7:0] bcast;
  logic [7:0] next_bcast;
  logic [1:0] ctl;
  logic [1:0] next_ctl;
  logic       clr_wr;

  assign clr_wr = i_wr_en && (i_addr == OFF_STATUS || i_addr == OFF_IRQ_MASK);

  // Shadows of software-written fields
  always_comb begin
    next_mask  = mask;
    next_bcast = bcast;
    next_ctl   = ctl;
    if (i_wr_en && i_addr == OFF_IRQ_MASK) next_mask = i_wr_data[7:0];
    if (i_wr_en && i_addr == OFF_PIN_CFG) next_bcast = i_wr_data[15:8];
    if (i_wr_en && i_addr == OFF_CTRL) next_ctl = i_wr_data[1:0];
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mask  <= 8'h00;
      bcast <= RST_BCAST;
      ctl   <= 2'h0;
    end else begin
      mask  <= next_mask;
      bcast <= next_bcast;
      ctl   <= next_ctl;
    end
  end

  function automatic logic [7:0] spread(input logic [31:0] w);
    return {{2{w[3]}}, {2{w[2]}}, {2{w[1]}}, {2{w[0]}}};
  endfunction

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_rd(a);
    i_rd_en && i_addr == a;
  endsequence
  sequence s_wr(a);
    i_wr_en && i_addr == a;
  endsequence

  property p_irq_level;
    s_rd(OFF_STATUS) |=>
      (((o_rd_data[7:0] & $past(mask)) != 8'h00) == $past(o_irq));
  endproperty
  property p_irq_hold;
    o_irq && !clr_wr |=> o_irq;
  endproperty
  property p_mask_off;
    s_wr(OFF_IRQ_MASK) ##0 i_wr_data[7:0] == 8'h00 |=> !o_irq;
  endproperty
  property p_sticky;
    s_rd(OFF_STATUS) ##1 s_rd(OFF_STATUS) |=>
      (o_rd_data & $past(o_rd_data)) == $past(o_rd_data);
  endproperty
  property p_frozen;
    s_rd(OFF_COUNT) ##1 (s_rd(OFF_COUNT) ##0 !ctl[0]) |=>
      o_rd_data == $past(o_rd_data);
  endproperty
  property p_rst_hold;
    s_rd(OFF_COUNT) ##0 (ctl[1] && $past(ctl[1])) |=> o_rd_data == 32'h0;
  endproperty
  property p_match_rw;
    s_wr(OFF_MATCH0) ##1 s_rd(OFF_MATCH0) |=>
      o_rd_data == $past(i_wr_data, 2);
  endproperty
  property p_ext_pins;
    s_wr(OFF_EXT_MATCH) ##0 (i_wr_data[11:4] == 8'h00 && !ctl[0]) |->
      ##2 o_match_pin == (spread($past(i_wr_data, 2)) & bcast);
  endproperty

  a_irq_level: assert property (p_irq_level)
    else $error("irq disagrees with status and mask");
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without a clear");
  a_mask_off: assert property (p_mask_off)
    else $error("irq high with mask zero");
  a_sticky: assert property (p_sticky)
    else $error("status flag lost without a clear");
  a_frozen: assert property (p_frozen)
    else $error("count moved while disabled");
  a_rst_hold: assert property (p_rst_hold)
    else $error("count not held at zero");
  a_match_rw: assert property (p_match_rw)
    else $error("match value readback wrong");
  a_ext_pins: assert property (p_ext_pins)
    else $error("match pins do not follow written states");
endmodule

bind capture_match_timer capture_match_timer_checker u_chk (
  .i_sys_clk   (i_sys_clk),
  .i_rst       (i_rst),
  .i_addr      (i_addr),
  .i_wr_data   (i_wr_data),
  .i_wr_en     (i_wr_en),
  .i_rd_en     (i_rd_en),
  .o_rd_data   (o_rd_data),
  .o_irq       (o_irq),
  .o_match_pin (o_match_pin)
);

//--- pin_model.sv
// External pin model: capture levels and count clock pulses.
// Assumes one caller at a time, entering just after a clock edge.
module pin_model
  import timer_pkg::*;
(
  input  wire logic                i_sys_clk,
  output logic      [NUM_PINS-1:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_pin = '0;

  task automatic set_pin(input int p, input logic v);
    @(posedge i_sys_clk);
    o_pin[p] <= v;
  endtask

  // Each level held for hold cycles; pin_sync needs two or more
  task automatic pulses(input int p, input int n, input int hold);
    repeat (n) begin
      set_pin(p, 1'b1);
      repeat (hold - 1) @(posedge i_sys_clk);
      set_pin(p, 1'b0);
      repeat (hold - 1) @(posedge i_sys_clk);
    end
  endtask
endmodule

//--- capture_match_timer_tb.sv
// Self-checking bench for the capture/match timer.
// Register port driven by NBA after rising edges; pin model on inputs.
module capture_match_timer_tb
  import timer_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;

  logic                i_sys_clk = 1'b0;
  logic                i_rst     = 1'b1;
  logic [ADDR_W-1:0]   i_addr    = '0;
  logic [DATA_W-1:0]   i_wr_data = '0;
  logic                i_wr_en   = 1'b0;
  logic                i_rd_en   = 1'b0;
  logic [DATA_W-1:0]   o_rd_data;
  logic                o_irq;
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] o_match_pin;
  logic                rd_seen   = 1'b0;
  logic [31:0]         exp_q[$];
  string               name_q[$];
  logic [31:0]         d;
  logic [31:0]         mv;
  int                  n;
  int                  errors    = 0;
  int                  n_tests   = 0;
  int                  cyc       = 0;

  capture_match_timer dut (
    .i_sys_clk           (i_sys_clk),
    .i_rst               (i_rst),
    .i_addr              (i_addr),
    .i_wr_data           (i_wr_data),
    .i_wr_en             (i_wr_en),
    .i_rd_en             (i_rd_en),
    .o_rd_data           (o_rd_data),
    .o_irq               (o_irq),
    .i_capture_input_pin (pins),
    .o_match_pin         (o_match_pin)
  );

  pin_model u_pins (
    .i_sys_clk (i_sys_clk),
    .o_pin     (pins)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_wr_en   <= 1'b1;
    i_rd_en   <= 1'b0;
    i_addr    <= a;
    i_wr_data <= v;
    @(posedge i_sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    i_rd_en <= 1'b1;
    i_wr_en <= 1'b0;
    i_addr  <= a;
    exp_q.push_back(e);
    name_q.push_back(nm);
    @(posedge i_sys_clk);
  endtask

  task automatic idle(input int k);
    i_rd_en <= 1'b0;
    i_wr_en <= 1'b0;
    repeat (k) @(posedge i_sys_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge i_sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0)
        chk("read queue", 32'h1, 32'h0);
      else
        chk(name_q.pop_front(), exp_q.pop_front(), o_rd_data);
    end
    rd_seen <= i_rd_en;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(7522));
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    rd(OFF_STATUS, 32'h0, "status");
    rd(OFF_PIN_CFG, 32'h0000_ff00, "pin_cfg");
    rd(8'h4c, 32'h0, "unmapped");
    d = $urandom;
    wr(OFF_MATCH0, d);
    rd(OFF_MATCH0, d, "match_value_0");
    wr(OFF_CAPTURE0, d);
    rd(OFF_CAPTURE0, 32'h0, "capture_value_0");
    idle(1);
    $display("test registers done");
    mv = 32'h3 + 32'($urandom_range(4));
    wr(OFF_EXT_MATCH, 32'h30);
    wr(OFF_IRQ_MASK, 32'h1);
    wr(OFF_MATCH_CTL, 32'h5);
    wr(OFF_MATCH0, mv);
    wr(OFF_PRESCALE, 32'h1);
    wr(OFF_CTRL, 32'h1);
    idle(2 * mv + 20);
    rd(OFF_COUNT, mv + 32'h1, "count");
    rd(OFF_CTRL, 32'h0, "ctrl");
    rd(OFF_STATUS, 32'h1, "status");
    rd(OFF_STATUS, 32'h1, "status");
    idle(1);
    chk("irq", 32'h1, 32'(o_irq));
    chk("match_pin", 32'h03, 32'(o_match_pin));
    wr(OFF_STATUS, 32'h1);
    idle(2);
    chk("irq", 32'h0, 32'(o_irq));
    $display("test stop match done");
    wr(OFF_CTRL, 32'h3);
    idle(3);
    rd(OFF_COUNT, 32'h0, "count");
    wr(OFF_CTRL, 32'h0);
    rd(OFF_COUNT, 32'h0, "count");
    rd(OFF_COUNT, 32'h0, "count");
    wr(OFF_EXT_MATCH, 32'h99);
    wr(OFF_MATCH_CTL, 32'h2a);
    wr(OFF_MATCH0, 32'h2);
    wr(OFF_MATCH0 + 8'h04, 32'h2);
    wr(OFF_PRESCALE, 32'h0);
    wr(OFF_CTRL, 32'h1);
    idle(12);
    rd(OFF_COUNT, 32'h0, "count");
    rd(OFF_STATUS, 32'h2, "status");
    idle(1);
    chk("irq", 32'h0, 32'(o_irq));
    chk("match_pin", 32'hcc, 32'(o_match_pin));
    wr(OFF_IRQ_MASK, 32'h2);
    idle(2);
    chk("irq", 32'h1, 32'(o_irq));
    wr(OFF_IRQ_MASK, 32'h0);
    idle(1);
    chk("irq", 32'h0, 32'(o_irq));
    wr(OFF_STATUS, 32'hff);
    idle(2);
    chk("irq", 32'h0, 32'(o_irq));
    $display("test reset match done");
    wr(OFF_MATCH_CTL, 32'h0);
    wr(OFF_CAP_CTL, 32'h28);
    n = 3 + $urandom_range(3);
    for (int m = 1; m < 4; m++) begin
      wr(OFF_COUNT_CTL, 32'(m));
      wr(OFF_COUNT, 32'h0);
      wr(OFF_CTRL, 32'h1);
      idle(1);
      u_pins.pulses(0, n, 2);
      idle(8);
      rd(OFF_COUNT, 32'(m == 3 ? 2 * n : n), "count");
      idle(1);
    end
    u_pins.set_pin(2, 1'b1);
    idle(8);
    rd(OFF_CAPTURE0 + 8'h04, 32'(2 * n), "capture");
    rd(OFF_STATUS, 32'h20, "status");
    $display("test event count done");
    wr(OFF_STATUS, 32'hff);
    wr(OFF_PIN_CFG, 32'h0000_fe04);
    wr(OFF_CAP_CTL, 32'h1c0);
    idle(1);
    u_pins.set_pin(4, 1'b1);
    idle(8);
    rd(OFF_STATUS, 32'h0, "status");
    idle(1);
    u_pins.set_pin(5, 1'b1);
    idle(8);
    rd(OFF_STATUS, 32'h40, "status");
    rd(OFF_CAPTURE0 + 8'h08, 32'(2 * n), "capture");
    wr(OFF_STATUS, 32'hff);
    idle(1);
    u_pins.set_pin(4, 1'b0);
    idle(8);
    rd(OFF_STATUS, 32'h40, "status");
    wr(OFF_CTRL, 32'h0);
    wr(OFF_EXT_MATCH, 32'h5);
    idle(3);
    chk("match_pin", 32'h32, 32'(o_match_pin));
    $display("test pin combine done");
    idle(2);
    report_and_stop();
  end
endmodule
